// ---- pshr_pkg.sv ----
package pshr_pkg;
  localparam logic [7:0] PSHR_ADDR_SHADOW = 8'h30;
  localparam logic [2:0] PSHR_SEL_AUX = 3'h0;
  localparam logic [2:0] PSHR_SEL_TENBT = 3'h1;
  localparam logic [2:0] PSHR_SEL_PWR = 3'h2;
  localparam logic [2:0] PSHR_SEL_TEST = 3'h4;
  localparam logic [2:0] PSHR_SEL_MISC = 3'h7;
  localparam int PSHR_SEL_LSB = 0;
  localparam int PSHR_RDSEL_LSB = 12;
  localparam int PSHR_MISC_FULL_BIT = 15;
  localparam int PSHR_AUX_LOOP_BIT = 15;
  localparam int PSHR_AUX_EXT_BIT = 14;
  localparam int PSHR_AUX_ER1G_LSB = 12;
  localparam int PSHR_AUX_ER100_LSB = 4;
  localparam logic [15:0] PSHR_AUX_RESET = 16'h0400;
  localparam logic [15:0] PSHR_AUX_RW_MASK = 16'hf030;
  localparam logic [15:0] PSHR_AUX_FORCE_ONE = 16'h0400;
  localparam logic [15:0] PSHR_TENBT_RESET = 16'h0000;
  localparam logic [15:0] PSHR_PWR_RESET = 16'h0060;
  localparam logic [15:0] PSHR_TEST_RESET = 16'h0000;
  localparam logic [15:0] PSHR_MISC_RESET = 16'h0000;
  localparam logic [15:0] PSHR_MISC_SEL_MASK = 16'h7000;
  typedef struct packed {
    logic loopback;
    logic ext_len;
    logic [1:0] edge_1g;
    logic [1:0] edge_100;
  } pshr_aux_t;
endpackage

// ---- pshr_shadow_reg.sv ----
`timescale 1ns/1ps
module pshr_shadow_reg
  import pshr_pkg::*;
#(
  parameter logic [15:0] RESET_VAL = 16'h0000,
  parameter logic [15:0] WR_MASK = 16'hfff8,
  parameter logic [15:0] FORCE_ONE = 16'h0000
)(
  input wire logic ref_clk_i,
  input wire logic reset_i,
  input wire logic clk_en_i,
  input wire logic wr_i,
  input wire logic [15:0] wdata_i,
  output logic [15:0] value_o
);
  always_ff @(posedge ref_clk_i or posedge reset_i)
  begin
    if (reset_i)
      value_o <= RESET_VAL;
    else if (clk_en_i && wr_i)
      value_o <= (wdata_i & WR_MASK) | (value_o & ~WR_MASK) | FORCE_ONE;
  end
endmodule

// ---- pshr_top.sv ----
`timescale 1ns/1ps
// Summary of operation
// - Select code 000 aux, 001 10BASE-T, 010 power, 100 test, 111 misc; others unused.
// - Reads return only the shadow named through the misc control target.
// - Misc write with bit 15 low updates only bits 14:12; bits 2:0 are kept.
// - Bits 14:12 of such a write become the latched read target.
// - Read of 30h returns the shadow named by the latched target.
// - Write bits 15:3 become the upper bits of the 10BASE-T, power or test shadow.
// - Write goes to the shadow coded in bits 2:0 of the word.
// - Aux bit 15 enables external loopback; resets to zero.
// - Aux bit 14 allows extended length reception in SGMII mode.
// - Aux bits 13:12 pick 1000BASE-T edge rate; reset 00.
// - Aux bits 5:4 pick 100BASE-TX edge rate; reset 00.
// - Aux bit 10 resets and stays one; other reserved bits ignored.
// - Aux field set applies when the select code is 000.
module pshr_top
  import pshr_pkg::*;
(
  input wire logic ref_clk_i,
  input wire logic reset_i,
  input wire logic clk_en_i,
  input wire logic [7:0] addr_i,
  input wire logic [15:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [15:0] rdata_o,
  output pshr_aux_t aux_ctrl_o,
  output logic [15:0] tenbt_ctrl_o,
  output logic [15:0] pwr_ctrl_o,
  output logic [15:0] test_ctrl_o,
  output logic [2:0] read_target_o
);
  logic hit;
  logic [2:0] wsel;
  logic wr_aux;
  logic wr_tenbt;
  logic wr_pwr;
  logic wr_test;
  logic wr_misc_full;
  logic wr_misc_sel;
  logic [15:0] aux_q;
  logic [15:0] tenbt_q;
  logic [15:0] pwr_q;
  logic [15:0] test_q;
  logic [15:0] misc_q;
  logic [15:0] misc_wdata;
  logic [15:0] next_rdata;
  logic [2:0] target;

  assign hit = (addr_i == PSHR_ADDR_SHADOW);
  assign wsel = wdata_i[PSHR_SEL_LSB +: 3];

  always_comb
  begin
    wr_aux = 1'b0;
    wr_tenbt = 1'b0;
    wr_pwr = 1'b0;
    wr_test = 1'b0;
    wr_misc_full = 1'b0;
    wr_misc_sel = 1'b0;
    if (wr_i && hit)
    begin
      case (wsel)
        PSHR_SEL_AUX: wr_aux = 1'b1;
        PSHR_SEL_TENBT: wr_tenbt = 1'b1;
        PSHR_SEL_PWR: wr_pwr = 1'b1;
        PSHR_SEL_TEST: wr_test = 1'b1;
        PSHR_SEL_MISC:
        begin
          if (wdata_i[PSHR_MISC_FULL_BIT])
            wr_misc_full = 1'b1;
          else
            wr_misc_sel = 1'b1;
        end
        default: wr_aux = 1'b0;
      endcase
    end
  end

  // Bits 11:3 kept on partial write
  assign misc_wdata = wr_misc_full ? wdata_i : ((wdata_i & PSHR_MISC_SEL_MASK) | (misc_q & ~PSHR_MISC_SEL_MASK));

  pshr_shadow_reg #(.RESET_VAL(PSHR_AUX_RESET), .WR_MASK(PSHR_AUX_RW_MASK), .FORCE_ONE(PSHR_AUX_FORCE_ONE)) u_aux (
    .ref_clk_i(ref_clk_i),
    .reset_i(reset_i),
    .clk_en_i(clk_en_i),
    .wr_i(wr_aux),
    .wdata_i(wdata_i),
    .value_o(aux_q)
  );
  pshr_shadow_reg #(.RESET_VAL(PSHR_TENBT_RESET)) u_tenbt (
    .ref_clk_i(ref_clk_i),
    .reset_i(reset_i),
    .clk_en_i(clk_en_i),
    .wr_i(wr_tenbt),
    .wdata_i(wdata_i),
    .value_o(tenbt_q)
  );
  pshr_shadow_reg #(.RESET_VAL(PSHR_PWR_RESET)) u_pwr (
    .ref_clk_i(ref_clk_i),
    .reset_i(reset_i),
    .clk_en_i(clk_en_i),
    .wr_i(wr_pwr),
    .wdata_i(wdata_i),
    .value_o(pwr_q)
  );
  pshr_shadow_reg #(.RESET_VAL(PSHR_TEST_RESET)) u_test (
    .ref_clk_i(ref_clk_i),
    .reset_i(reset_i),
    .clk_en_i(clk_en_i),
    .wr_i(wr_test),
    .wdata_i(wdata_i),
    .value_o(test_q)
  );
  pshr_shadow_reg #(.RESET_VAL(PSHR_MISC_RESET)) u_misc (
    .ref_clk_i(ref_clk_i),
    .reset_i(reset_i),
    .clk_en_i(clk_en_i),
    .wr_i(wr_misc_full | wr_misc_sel),
    .wdata_i(misc_wdata),
    .value_o(misc_q)
  );

  assign target = misc_q[PSHR_RDSEL_LSB +: 3];

  always_comb
  begin
    case (target)
      PSHR_SEL_AUX: next_rdata = (aux_q & PSHR_AUX_RW_MASK) | PSHR_AUX_FORCE_ONE;
      PSHR_SEL_TENBT: next_rdata = tenbt_q;
      PSHR_SEL_PWR: next_rdata = pwr_q;
      PSHR_SEL_TEST: next_rdata = test_q;
      PSHR_SEL_MISC: next_rdata = misc_q;
      default: next_rdata = 16'h0000;
    endcase
    next_rdata[PSHR_SEL_LSB +: 3] = target;
  end

  always_ff @(posedge ref_clk_i or posedge reset_i)
  begin
    if (reset_i)
      rdata_o <= 16'h0000;
    else if (clk_en_i)
      rdata_o <= (rd_i && hit) ? next_rdata : 16'h0000;
  end

  // Loopback, extended length, edge rates, plus 10BASE-T, power and test shadows and read target
  always_ff @(posedge ref_clk_i or posedge reset_i)
  begin
    if (reset_i)
    begin
      aux_ctrl_o <= '0;
      tenbt_ctrl_o <= PSHR_TENBT_RESET;
      pwr_ctrl_o <= PSHR_PWR_RESET;
      test_ctrl_o <= PSHR_TEST_RESET;
      read_target_o <= PSHR_SEL_AUX;
    end
    else if (clk_en_i)
    begin
      aux_ctrl_o.loopback <= aux_q[PSHR_AUX_LOOP_BIT];
      aux_ctrl_o.ext_len <= aux_q[PSHR_AUX_EXT_BIT];
      aux_ctrl_o.edge_1g <= aux_q[PSHR_AUX_ER1G_LSB +: 2];
      aux_ctrl_o.edge_100 <= aux_q[PSHR_AUX_ER100_LSB +: 2];
      tenbt_ctrl_o <= tenbt_q;
      pwr_ctrl_o <= pwr_q;
      test_ctrl_o <= test_q;
      read_target_o <= target;
    end
  end
endmodule

// ---- pshr_chk.sv ----
`timescale 1ns/1ps
module pshr_chk
  import pshr_pkg::*;
(
  input wire logic ref_clk_i,
  input wire logic reset_i,
  input wire logic clk_en_i,
  input wire logic [7:0] addr_i,
  input wire logic [15:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  input wire logic [15:0] rdata_o,
  input wire pshr_aux_t aux_ctrl_o,
  input wire logic [15:0] tenbt_ctrl_o,
  input wire logic [15:0] pwr_ctrl_o,
  input wire logic [15:0] test_ctrl_o,
  input wire logic [2:0] read_target_o
);
  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (reset_i);
  // Outputs trail storage by one cycle, so the enable must hold one more edge
  sequence s_wr(logic [2:0] s);
    wr_i && clk_en_i && addr_i == 8'h30 && wdata_i[2:0] == s ##1 clk_en_i;
  endsequence
  a_target_latch: assert property (s_wr(3'h7) |=> read_target_o == $past(wdata_i[14:12], 2))
    else $error("read target wrong");
  a_aux_fields: assert property (s_wr(3'h0) |=> aux_ctrl_o == $past({wdata_i[15:12], wdata_i[5:4]}, 2))
    else $error("aux fields wrong");
  a_tenbt_upper: assert property (s_wr(3'h1) |=> tenbt_ctrl_o[15:3] == $past(wdata_i[15:3], 2))
    else $error("tenbt wrong");
  a_test_upper: assert property (s_wr(3'h4) |=> test_ctrl_o[15:3] == $past(wdata_i[15:3], 2))
    else $error("test wrong");
  a_others_kept: assert property (s_wr(3'h1) |=> $stable(pwr_ctrl_o) && $stable(test_ctrl_o) && $stable(aux_ctrl_o))
    else $error("other shadow changed");
  a_refused_write: assert property ((wr_i && clk_en_i &&
    (addr_i != 8'h30 || wdata_i[2:0] inside {3'h3, 3'h5, 3'h6}) ##1 clk_en_i) |=> $stable(tenbt_ctrl_o) && $stable(read_target_o))
    else $error("refused write stored");
  a_read_idle: assert property (clk_en_i && !(rd_i && addr_i == 8'h30) |=> rdata_o == 16'h0)
    else $error("read data outside read");
  a_aux_read: assert property (rd_i && clk_en_i && addr_i == 8'h30 && read_target_o == 3'h0 &&
    $past(clk_en_i) && !$past(wr_i) |=> rdata_o[11:10] == 2'b01 && rdata_o[2:0] == 3'h0)
    else $error("aux read wrong");
  c_misc_select: cover property (s_wr(3'h7));
  c_aux_read: cover property (rd_i && addr_i == 8'h30 && read_target_o == 3'h0);
  c_unmapped_read: cover property (rd_i && addr_i != 8'h30);
endmodule
bind pshr_top pshr_chk u_chk (
  .ref_clk_i(ref_clk_i),
  .reset_i(reset_i),
  .clk_en_i(clk_en_i),
  .addr_i(addr_i),
  .wdata_i(wdata_i),
  .wr_i(wr_i),
  .rd_i(rd_i),
  .rdata_o(rdata_o),
  .aux_ctrl_o(aux_ctrl_o),
  .tenbt_ctrl_o(tenbt_ctrl_o),
  .pwr_ctrl_o(pwr_ctrl_o),
  .test_ctrl_o(test_ctrl_o),
  .read_target_o(read_target_o)
);

// ---- tb.sv ----
`timescale 1ns/1ps
module tb;
  import pshr_pkg::*;
  logic ref_clk_i = 1'b0, reset_i = 1'b1, wr_i = 1'b0, rd_i = 1'b0, clk_en_i = 1'b1;
  logic [7:0] addr_i = 8'h30;
  logic [15:0] wdata_i = 16'h0, rdata_o, tenbt_ctrl_o, pwr_ctrl_o, test_ctrl_o;
  logic [2:0] read_target_o;
  pshr_aux_t aux_ctrl_o;
  int bad_count = 0, checks = 0;
  `define CHK(a, b) begin checks++; if ((a) !== (b)) begin bad_count++; $display("unexpected %0t %h %h", $time, a, b); end end
  pshr_top dut (
    .ref_clk_i(ref_clk_i),
    .reset_i(reset_i),
    .clk_en_i(clk_en_i),
    .addr_i(addr_i),
    .wdata_i(wdata_i),
    .wr_i(wr_i),
    .rd_i(rd_i),
    .rdata_o(rdata_o),
    .aux_ctrl_o(aux_ctrl_o),
    .tenbt_ctrl_o(tenbt_ctrl_o),
    .pwr_ctrl_o(pwr_ctrl_o),
    .test_ctrl_o(test_ctrl_o),
    .read_target_o(read_target_o)
  );
  always #2.5 ref_clk_i = ~ref_clk_i;
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge ref_clk_i);
    addr_i <= a;
    wdata_i <= d;
    wr_i <= 1'b1;
    @(posedge ref_clk_i);
    wr_i <= 1'b0;
    @(posedge ref_clk_i);
    #1;
  endtask
  task automatic rd(input logic [7:0] a, input logic [15:0] e);
    @(posedge ref_clk_i);
    addr_i <= a;
    rd_i <= 1'b1;
    @(posedge ref_clk_i);
    rd_i <= 1'b0;
    #1;
    `CHK(rdata_o, e)
  endtask
  // Bits 11:3 set on purpose; they must be ignored
  task automatic rt(input logic [2:0] t, input logic [15:0] e);
    wr(8'h30, {1'b0, t, 9'h1ff, 3'h7});
    rd(8'h30, e);
  endtask
  task automatic t_reset;
    rt(3'h0, 16'h0400);
    `CHK(pwr_ctrl_o, 16'h0060)
    rt(3'h1, 16'h0001);
    rt(3'h2, 16'h0062);
    rt(3'h4, 16'h0004);
    // Unused code reads zero apart from the echoed select
    rt(3'h3, 16'h0003);
    rt(3'h7, 16'h7007);
  endtask
  // Reserved aux bits written as the rules ask: bit 10 one, others zero
  task automatic t_aux;
    wr(8'h30, 16'hf430);
    `CHK(aux_ctrl_o, 6'h3f)
    rt(3'h0, 16'hf430);
    for (int c = 0; c < 4; c++)
    begin
      wr(8'h30, {2'b00, c[1:0], 6'h10, c[1:0], 4'h0});
      `CHK(aux_ctrl_o, {2'b00, c[1:0], c[1:0]})
    end
  endtask
  task automatic t_others;
    wr(8'h30, 16'habc9);
    `CHK(tenbt_ctrl_o[15:3], 13'h1579)
    wr(8'h30, 16'h5555);
    wr(8'h31, 16'h0001);
    `CHK(tenbt_ctrl_o[15:3], 13'h1579)
    rd(8'h31, 16'h0000);
    wr(8'h30, 16'h8884);
    `CHK(test_ctrl_o[15:3], 13'h1110)
    `CHK(pwr_ctrl_o, 16'h0060)
    rt(3'h1, 16'habc9);
    wr(8'h30, 16'hc0ff);
    `CHK(read_target_o, 3'h4)
    rd(8'h30, 16'h8884);
    rt(3'h7, 16'hf0ff);
  endtask
  // Enable low must swallow both a write and a read
  task automatic t_freeze;
    @(posedge ref_clk_i);
    clk_en_i <= 1'b0;
    wr(8'h30, 16'h1231);
    `CHK(tenbt_ctrl_o[15:3], 13'h1579)
    rd(8'h30, 16'h0000);
    @(posedge ref_clk_i);
    clk_en_i <= 1'b1;
    rd(8'h30, 16'hf0ff);
    `CHK(tenbt_ctrl_o[15:3], 13'h1579)
  endtask
  task automatic stop_test;
    if (bad_count == 0 && checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  initial
  begin
    repeat (8) @(posedge ref_clk_i);
    reset_i <= 1'b0;
    t_reset;
    t_aux;
    t_others;
    t_freeze;
    stop_test;
  end
  // Whole run needs under 1 us; far margin
  initial
  begin
    #20000;
    bad_count++;
    stop_test;
  end
endmodule
